// File: hdl/tcc_consts.svh
// Register indices, field positions, reset values and timing counts.
// Assumes a byte-addressed APB slave where byte address = 4 * index.
// Notes on behaviour
// (R1) Width code 0 is 16-bit, 1 is 8-bit, 2 is 32-bit, 3 reserved.
// (R2) Enable reads back at once; busy flag set until enabling completes.
// (R3) Enable and soft reset stay writable while the timer runs.
// (R4) Soft reset one restores all registers except debug, timer disabled.
// (R5) A soft reset write discards all other fields of that write.
// (R6) Control B has clear and set aliases reading the same contents.
// (R7) Nonzero command runs on next prescaled tick, then reads zero.
// (R8) Any command bit written one via clear alias cancels pending command.
// (R9) Command 1 starts or retriggers; command 2 stops the counter.
// (R10) Command 3 forces buffer update; command 4 forces count read sync.
// (R11) One-shot off wraps and runs on; one-shot on wraps and stops.
// (R12) One-shot set via set alias, cleared via clear alias.
// (R13) Unlocked hardware update copies buffers; locked, no copy.
// (R14) Update lock is ignored on a channel with capture enabled.
// (R15) Update lock set via set alias, released via clear alias.
// (R16) Direction zero counts up, one down; set alias selects down.
// (R17) Channel event output enables at bits 12 and 13 pass match events.
// (R18) Wrap event output enable at bit 8 passes wrap events.
// (R19) Input event enable at bit 5 gates incoming events.
// (R20) Input invert at bit 4 inverts incoming event source.
// (R21) Event action selects none, retrigger, count, start or captures.
// (R22) Enable-protected registers accept writes only while disabled.
// (R23) Direction one via clear alias returns counting up.
// (R24) Software polls enable busy flag before relying on new state.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_IDX_PRIMARY     6'h00
`define TCC_IDX_SECONDARY_CONTROL_CLR   6'h04
`define TCC_IDX_SECONDARY_CONTROL_SET   6'h05
`define TCC_IDX_EVENT_CFG   6'h06
`define TCC_IDX_STATUS      6'h0B
`define TCC_IDX_SYNC_BUSY   6'h10

`define TCC_BIT_SOFT_RESET_BIT       0
`define TCC_BIT_ENABLE      1
`define TCC_LSB_MODE        2
`define TCC_LSB_CAPTEN      16

`define TCC_BIT_DIR         0
`define TCC_BIT_LOCK        1
`define TCC_BIT_SINGLE_RUN_BIT     2
`define TCC_LSB_CMD         5

`define TCC_LSB_EVENT_ACTION_FIELD       0
`define TCC_BIT_EVINV       4
`define TCC_BIT_EVEN        5
`define TCC_BIT_WRAPEO      8
`define TCC_LSB_MCEO        12

`define TCC_BIT_STOP        0
`define TCC_BIT_BUSY_SOFT_RESET_BIT  0
`define TCC_BIT_BUSY_ENABLE 1

`define TCC_RST_STOPPED     1'b1
`define TCC_RST_WIDTH_SEL   3'h2
`define TCC_SYNC_CYCLES     2'h3

`endif

// File: hdl/tcc_pkg.sv
// Types shared by the timer control block and its synchroniser.
// Assumes the constants header is included by the files that need it.
package tcc_pkg;

    typedef enum logic [1:0] {
        TCC_W16,
        TCC_W8,
        TCC_W32,
        TCC_WRSV
    } tcc_width_t;

    typedef enum logic [2:0] {
        TCC_CMD_NONE,
        TCC_CMD_RETRIGGER,
        TCC_CMD_STOP,
        TCC_CMD_UPDATE,
        TCC_CMD_COUNT_READ_SYNC_CMD
    } tcc_cmd_t;

    typedef enum logic [2:0] {
        TCC_EV_OFF,
        TCC_EV_RETRIGGER,
        TCC_EV_COUNT,
        TCC_EV_START,
        TCC_EV_STAMP,
        TCC_EV_PPW,
        TCC_EV_PWP,
        TCC_EV_PW
    } tcc_event_action_field_t;

    typedef struct packed {
        logic meta;
        logic q;
    } tcc_sync_t;

    typedef struct packed {
        logic        enable;
        tcc_width_t  mode;
        logic [1:0]  capt_en;
        tcc_cmd_t    pend_cmd;
        logic        one_shot;
        logic        lock;
        logic        dir;
        tcc_event_action_field_t  ev_action;
        logic        ev_inv;
        logic        ev_en;
        logic        wrap_eo;
        logic [1:0]  mc_eo;
        logic        enabled_act;
        logic        busy_en;
        logic        busy_sw;
        logic [1:0]  sync_cnt;
        logic        stopped;
        logic        ev_prev;
        logic [2:0]  width_sel;
        logic        cmd_retrig;
        logic        cmd_stop;
        logic        cmd_update;
        logic        cmd_rsync;
        logic [1:0]  chan_copy;
        logic        per_copy;
        logic        ev_retrig;
        logic        ev_count;
        logic        ev_start;
        logic        ev_capture;
        logic [1:0]  ev_out_mc;
        logic        ev_out_wrap;
        logic [31:0] rdata;
        logic        rerr;
    } tcc_state_t;

endpackage

// File: hdl/tcc_sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
module tcc_sync2
    import tcc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);

    tcc_sync_t s;
    tcc_sync_t next_s;

    always_comb
    begin
        next_s.meta = d_i;
        next_s.q    = s.meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign q_o = s.q;

endmodule

// File: hdl/tcc_top.sv
// Timer/counter control path: control registers, commands and events.
// Assumes an APB master, a prescaler tick and a counter datapath on the
// same clock; only the event input is asynchronous.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_top
    import tcc_pkg::*;
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        PRESC_TICK_I,
    input  wire logic        WRAP_I,
    input  wire logic [1:0]  MATCH_I,
    input  wire logic        HW_UPDATE_I,
    input  wire logic        EVENT_I,
    output logic             ENABLED_O,
    output logic [2:0]       WIDTH_SEL_O,
    output logic             DIR_DOWN_O,
    output logic             ONE_SHOT_O,
    output logic             RUN_O,
    output logic [1:0]       CAPTURE_EN_O,
    output logic             CMD_RETRIGGER_O,
    output logic             CMD_STOP_O,
    output logic             CMD_UPDATE_O,
    output logic             CMD_COUNT_READ_SYNC_CMD_O,
    output logic [1:0]       CHAN_COPY_O,
    output logic             PERIOD_COPY_O,
    output logic             EV_RETRIGGER_O,
    output logic             EV_COUNT_O,
    output logic             EV_START_O,
    output logic             EV_CAPTURE_O,
    output logic [2:0]       EV_ACTION_O,
    output logic [1:0]       EV_OUT_MATCH_O,
    output logic             EV_OUT_WRAP_O
);

    localparam tcc_state_t TCC_RESET = '{
        mode:      TCC_W16,
        pend_cmd:  TCC_CMD_NONE,
        ev_action: TCC_EV_OFF,
        stopped:   `TCC_RST_STOPPED,
        width_sel: `TCC_RST_WIDTH_SEL,
        default:   '0
    };

    tcc_state_t s;
    tcc_state_t next_s;

    logic       ev_sync;
    logic       ev_level;
    logic       ev_edge;
    logic       wr_access;
    logic       rd_setup;
    logic       aligned;
    logic [5:0] reg_idx;
    logic       locked;
    logic       run_clear;
    logic       run_set;
    tcc_cmd_t   exec_cmd;
    logic [2:0] wr_cmd;

    tcc_sync2 u_event_sync
    (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .d_i   (EVENT_I),
        .q_o   (ev_sync)
    );

    always_comb
    begin
        next_s    = s;
        wr_access = PSEL_I & PENABLE_I & PWRITE_I;
        rd_setup  = PSEL_I & ~PENABLE_I;
        aligned   = (PADDR_I[1:0] == 2'h0);
        reg_idx   = PADDR_I[7:2];
        wr_cmd    = PWDATA_I[`TCC_LSB_CMD +: 3];
        // Running or still synchronising counts as enabled for protection.
        locked    = s.enable | s.enabled_act; // (R22)
        run_clear = 1'b0;
        run_set   = 1'b0;
        exec_cmd  = TCC_CMD_NONE;

        next_s.cmd_retrig  = 1'b0;
        next_s.cmd_stop    = 1'b0;
        next_s.cmd_update  = 1'b0;
        next_s.cmd_rsync   = 1'b0;
        next_s.ev_retrig   = 1'b0;
        next_s.ev_count    = 1'b0;
        next_s.ev_start    = 1'b0;
        next_s.ev_capture  = 1'b0;

        // Input event path; the inverted level is edge detected so that a
        // held level fires once, not on every clock.
        ev_level       = ev_sync ^ s.ev_inv; // (R20)
        next_s.ev_prev = ev_level;
        ev_edge        = ev_level & ~s.ev_prev & s.ev_en & s.enabled_act; // (R19)
        if (ev_edge)
        begin
            case (s.ev_action) // (R21)
                TCC_EV_OFF: ;
                TCC_EV_RETRIGGER:
                begin
                    next_s.ev_retrig = 1'b1;
                    run_clear        = 1'b1;
                end
                TCC_EV_COUNT: next_s.ev_count = 1'b1;
                TCC_EV_START:
                begin
                    next_s.ev_start = 1'b1;
                    run_clear       = s.stopped;
                end
                default:
                begin
                    next_s.ev_capture = 1'b1;
                end
            endcase
        end

        next_s.ev_out_mc   = MATCH_I & s.mc_eo; // (R17)
        next_s.ev_out_wrap = WRAP_I & s.wrap_eo; // (R18)

        // Pending command runs on the prescaled tick and then reads zero.
        if (PRESC_TICK_I && (s.pend_cmd != TCC_CMD_NONE)) // (R7)
        begin
            exec_cmd        = s.pend_cmd;
            next_s.pend_cmd = TCC_CMD_NONE;
        end
        case (exec_cmd)
            TCC_CMD_RETRIGGER:
            begin
                next_s.cmd_retrig = 1'b1; // (R9)
                run_clear         = s.enabled_act;
            end
            TCC_CMD_STOP:
            begin
                next_s.cmd_stop = 1'b1; // (R9)
                run_set         = 1'b1;
            end
            TCC_CMD_UPDATE:   next_s.cmd_update = 1'b1; // (R10)
            TCC_CMD_COUNT_READ_SYNC_CMD: next_s.cmd_rsync  = 1'b1; // (R10)
            default: ;
        endcase

        // A forced update copies regardless of the lock; a hardware one
        // honours the lock except on capture channels.
        next_s.chan_copy = ({2{HW_UPDATE_I}} & ({2{~s.lock}} | s.capt_en))
                         | {2{exec_cmd == TCC_CMD_UPDATE}}; // (R13) (R14)
        next_s.per_copy  = (HW_UPDATE_I & ~s.lock)
                         | (exec_cmd == TCC_CMD_UPDATE); // (R13)

        // Stop sources are applied after start sources so a coincident
        // stop is never lost.
        run_set = run_set | ~s.enabled_act
                | (WRAP_I & s.one_shot & s.enabled_act); // (R11)
        next_s.stopped = run_set | (s.stopped & ~run_clear);

        // Enable synchronisation; the new state lands when the count ends.
        if (s.busy_en || s.busy_sw)
        begin
            if (s.sync_cnt == 2'h0)
            begin
                next_s.enabled_act = s.enable; // (R2)
                next_s.busy_en     = 1'b0;
                next_s.busy_sw     = 1'b0;
            end
            else
            begin
                next_s.sync_cnt = s.sync_cnt - 2'h1;
            end
        end

        if (wr_access && aligned)
        begin
            case (reg_idx)
                `TCC_IDX_PRIMARY:
                begin
                    if (PSTRB_I[0] && PWDATA_I[`TCC_BIT_SOFT_RESET_BIT]) // (R3)
                    begin
                        // Everything in this write is dropped.
                        next_s          = TCC_RESET; // (R4) (R5)
                        next_s.busy_sw  = 1'b1;
                        next_s.sync_cnt = `TCC_SYNC_CYCLES;
                    end
                    else
                    begin
                        if (PSTRB_I[0] &&
                            (PWDATA_I[`TCC_BIT_ENABLE] != s.enable)) // (R3)
                        begin
                            next_s.enable   = PWDATA_I[`TCC_BIT_ENABLE];
                            next_s.busy_en  = 1'b1; // (R2)
                            next_s.sync_cnt = `TCC_SYNC_CYCLES;
                        end
                        if (PSTRB_I[0] && !locked) // (R22)
                        begin
                            next_s.mode =
                                tcc_width_t'(PWDATA_I[`TCC_LSB_MODE +: 2]);
                        end
                        if (PSTRB_I[2] && !locked) // (R22)
                        begin
                            next_s.capt_en = PWDATA_I[`TCC_LSB_CAPTEN +: 2];
                        end
                    end
                end
                `TCC_IDX_SECONDARY_CONTROL_CLR:
                begin
                    if (PSTRB_I[0])
                    begin
                        if (wr_cmd != 3'h0)
                        begin
                            next_s.pend_cmd = TCC_CMD_NONE; // (R8)
                        end
                        if (PWDATA_I[`TCC_BIT_SINGLE_RUN_BIT])
                        begin
                            next_s.one_shot = 1'b0; // (R12)
                        end
                        if (PWDATA_I[`TCC_BIT_LOCK])
                        begin
                            next_s.lock = 1'b0; // (R15)
                        end
                        if (PWDATA_I[`TCC_BIT_DIR])
                        begin
                            next_s.dir = 1'b0; // (R23)
                        end
                    end
                end
                `TCC_IDX_SECONDARY_CONTROL_SET:
                begin
                    if (PSTRB_I[0])
                    begin
                        if (wr_cmd != 3'h0)
                        begin
                            next_s.pend_cmd = tcc_cmd_t'(wr_cmd); // (R7)
                        end
                        if (PWDATA_I[`TCC_BIT_SINGLE_RUN_BIT])
                        begin
                            next_s.one_shot = 1'b1; // (R12)
                        end
                        if (PWDATA_I[`TCC_BIT_LOCK])
                        begin
                            next_s.lock = 1'b1; // (R15)
                        end
                        if (PWDATA_I[`TCC_BIT_DIR])
                        begin
                            next_s.dir = 1'b1; // (R16)
                        end
                    end
                end
                `TCC_IDX_EVENT_CFG:
                begin
                    if (PSTRB_I[0] && !locked) // (R22)
                    begin
                        next_s.ev_action =
                            tcc_event_action_field_t'(PWDATA_I[`TCC_LSB_EVENT_ACTION_FIELD +: 3]);
                        next_s.ev_inv    = PWDATA_I[`TCC_BIT_EVINV];
                        next_s.ev_en     = PWDATA_I[`TCC_BIT_EVEN];
                    end
                    if (PSTRB_I[1] && !locked) // (R22)
                    begin
                        next_s.wrap_eo = PWDATA_I[`TCC_BIT_WRAPEO];
                        next_s.mc_eo   = PWDATA_I[`TCC_LSB_MCEO +: 2];
                    end
                end
                default: ;
            endcase
        end

        case (next_s.mode) // (R1)
            TCC_W16: next_s.width_sel = 3'h2;
            TCC_W8:  next_s.width_sel = 3'h1;
            TCC_W32: next_s.width_sel = 3'h4;
            default: next_s.width_sel = 3'h0;
        endcase

        // Read data is captured in the setup cycle for the access cycle.
        if (rd_setup)
        begin
            next_s.rdata = 32'h0000_0000;
            next_s.rerr  = ~aligned;
            case (reg_idx)
                `TCC_IDX_PRIMARY:
                begin
                    next_s.rdata[`TCC_BIT_ENABLE]     = s.enable; // (R2)
                    next_s.rdata[`TCC_LSB_MODE +: 2]  = s.mode;
                    next_s.rdata[`TCC_LSB_CAPTEN +: 2] = s.capt_en;
                end
                `TCC_IDX_SECONDARY_CONTROL_CLR,
                `TCC_IDX_SECONDARY_CONTROL_SET:
                begin
                    next_s.rdata[`TCC_LSB_CMD +: 3]  = s.pend_cmd; // (R6)
                    next_s.rdata[`TCC_BIT_SINGLE_RUN_BIT]   = s.one_shot;
                    next_s.rdata[`TCC_BIT_LOCK]      = s.lock;
                    next_s.rdata[`TCC_BIT_DIR]       = s.dir;
                end
                `TCC_IDX_EVENT_CFG:
                begin
                    next_s.rdata[`TCC_LSB_EVENT_ACTION_FIELD +: 3] = s.ev_action;
                    next_s.rdata[`TCC_BIT_EVINV]      = s.ev_inv;
                    next_s.rdata[`TCC_BIT_EVEN]       = s.ev_en;
                    next_s.rdata[`TCC_BIT_WRAPEO]     = s.wrap_eo;
                    next_s.rdata[`TCC_LSB_MCEO +: 2]  = s.mc_eo;
                end
                `TCC_IDX_STATUS: next_s.rdata[`TCC_BIT_STOP] = s.stopped;
                `TCC_IDX_SYNC_BUSY:
                begin
                    // Software waits on these before trusting the enable.
                    next_s.rdata[`TCC_BIT_BUSY_SOFT_RESET_BIT]  = s.busy_sw; // (R24)
                    next_s.rdata[`TCC_BIT_BUSY_ENABLE] = s.busy_en;
                end
                default:
                begin
                    next_s.rerr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            s <= TCC_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign PRDATA_O        = s.rdata;
    assign PREADY_O        = 1'b1;
    assign PSLVERR_O       = PSEL_I & PENABLE_I & s.rerr;
    assign ENABLED_O       = s.enabled_act;
    assign WIDTH_SEL_O     = s.width_sel;
    assign DIR_DOWN_O      = s.dir; // (R16)
    assign ONE_SHOT_O      = s.one_shot;
    assign RUN_O           = ~s.stopped;
    assign CAPTURE_EN_O    = s.capt_en;
    assign CMD_RETRIGGER_O = s.cmd_retrig;
    assign CMD_STOP_O      = s.cmd_stop;
    assign CMD_UPDATE_O    = s.cmd_update;
    assign CMD_COUNT_READ_SYNC_CMD_O  = s.cmd_rsync;
    assign CHAN_COPY_O     = s.chan_copy;
    assign PERIOD_COPY_O   = s.per_copy;
    assign EV_RETRIGGER_O  = s.ev_retrig;
    assign EV_COUNT_O      = s.ev_count;
    assign EV_START_O      = s.ev_start;
    assign EV_CAPTURE_O    = s.ev_capture;
    assign EV_ACTION_O     = s.ev_action;
    assign EV_OUT_MATCH_O  = s.ev_out_mc;
    assign EV_OUT_WRAP_O   = s.ev_out_wrap;

endmodule

// File: bench/tcc_sva.sv
// Checker for the timer control block, bound onto its top module.
// Assumes only the top ports and the synchronous active-high reset.
`timescale 1ns/1ps
module tcc_sva
(
    input wire logic        CORE_CLK_I,
    input wire logic        RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PRESC_TICK_I,
    input wire logic        WRAP_I,
    input wire logic        HW_UPDATE_I,
    input wire logic        ENABLED_O,
    input wire logic        DIR_DOWN_O,
    input wire logic        ONE_SHOT_O,
    input wire logic        RUN_O,
    input wire logic [1:0]  CAPTURE_EN_O,
    input wire logic        CMD_STOP_O,
    input wire logic [1:0]  CHAN_COPY_O,
    input wire logic        EV_OUT_WRAP_O,
    input wire logic        EV_RETRIGGER_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // Lanes are not watched, so partial-strobe writes would mislead this.
    wire wr_ok = PSEL_I && PENABLE_I && PWRITE_I;

    property p_wrap;
        EV_OUT_WRAP_O |-> $past(WRAP_I);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("stray wrap event");
    property p_one_stop;
        WRAP_I && ONE_SHOT_O && ENABLED_O |-> ##[1:2] !RUN_O;
    endproperty
    a_one_stop: assert property (p_one_stop)
        else $error("one-shot did not stop");
    property p_capt;
        HW_UPDATE_I && CAPTURE_EN_O[0] |=> CHAN_COPY_O[0];
    endproperty
    a_capt: assert property (p_capt)
        else $error("capture channel not copied");
    property p_tick;
        CMD_STOP_O |-> $past(PRESC_TICK_I) || $past(PRESC_TICK_I, 2);
    endproperty
    a_tick: assert property (p_tick)
        else $error("command without tick");
    property p_stop;
        CMD_STOP_O |-> ##[0:2] !RUN_O;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop command ignored");
    property p_gate;
        EV_RETRIGGER_O |-> $past(ENABLED_O);
    endproperty
    a_gate: assert property (p_gate)
        else $error("event while disabled");
    property p_one_set;
        wr_ok && PADDR_I == 8'h14 && PWDATA_I[2] |-> ##[1:2] ONE_SHOT_O;
    endproperty
    a_one_set: assert property (p_one_set)
        else $error("one-shot not set");
    property p_dir_clr;
        wr_ok && PADDR_I == 8'h10 && PWDATA_I[0] |-> ##[1:2] !DIR_DOWN_O;
    endproperty
    a_dir_clr: assert property (p_dir_clr)
        else $error("direction not cleared");
    property p_soft_reset_bit;
        wr_ok && PADDR_I == 8'h00 && PWDATA_I[0]
            |-> ##[1:5] !ENABLED_O && !ONE_SHOT_O;
    endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit)
        else $error("soft reset incomplete");
endmodule

bind tcc_top tcc_sva u_sva (.*);

// File: bench/tcc_fabric.sv
// Far-side model: prescaled tick source and event fabric pulses.
// Assumes bench requests on the same clock; the tick free-runs when on.
`timescale 1ns/1ps
module tcc_fabric
#(
    parameter int DIV = 4
)
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_en_i,
    input  wire logic [3:0] fire_i,
    input  wire logic       ev_lvl_i,
    output logic            tick_o,
    output logic            wrap_o,
    output logic [1:0]      match_o,
    output logic            upd_o,
    output logic            ev_o
);
    int cnt = 0;

    initial
    begin
        {tick_o, wrap_o, match_o, upd_o, ev_o} = 6'h00;
    end

    // Pulses last one cycle, as a real event channel delivers them.
    always @(posedge clk_i)
    begin
        cnt <= (rst_i || cnt == DIV - 1) ? 0 : cnt + 1;
        tick_o <= tick_en_i && cnt == 0;
        {upd_o, match_o, wrap_o} <= fire_i;
        ev_o <= ev_lvl_i;
    end
endmodule

// File: bench/tb_top.sv
// Bench for the timer control block: APB tasks and directed tests.
// Assumes the fabric model supplies ticks, wraps, matches and events.
`timescale 1ns/1ps
module tb_top;
    logic        CORE_CLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I;
    logic        PREADY_O, PSLVERR_O, PRESC_TICK_I, WRAP_I, HW_UPDATE_I;
    logic        EVENT_I, ENABLED_O, DIR_DOWN_O, ONE_SHOT_O, RUN_O;
    logic        CMD_RETRIGGER_O, CMD_STOP_O, CMD_UPDATE_O, CMD_COUNT_READ_SYNC_CMD_O;
    logic        PERIOD_COPY_O, EV_RETRIGGER_O, EV_COUNT_O, EV_START_O;
    logic        EV_CAPTURE_O, EV_OUT_WRAP_O, rerr, tick_en, ev_lvl, clr;
    logic [1:0]  MATCH_I, CAPTURE_EN_O, CHAN_COPY_O, EV_OUT_MATCH_O;
    logic [2:0]  WIDTH_SEL_O, EV_ACTION_O;
    logic [3:0]  PSTRB_I, fire;
    logic [7:0]  PADDR_I;
    logic [13:0] seen;
    logic [31:0] PWDATA_I, PRDATA_O, rdat;
    logic [2:0]  wsel [4] = '{3'h1, 3'h4, 3'h0, 3'h2};
    int          n_errors, cmp_count, i;

    tcc_top dut (.*);
    tcc_fabric fab
    (
        .clk_i     (CORE_CLK_I),
        .rst_i     (RST_I),
        .tick_en_i (tick_en),
        .fire_i    (fire),
        .ev_lvl_i  (ev_lvl),
        .tick_o    (PRESC_TICK_I),
        .wrap_o    (WRAP_I),
        .match_o   (MATCH_I),
        .upd_o     (HW_UPDATE_I),
        .ev_o      (EVENT_I)
    );

    initial
    begin
        CORE_CLK_I = 1'b0;
        forever #50 CORE_CLK_I = ~CORE_CLK_I;
    end

    // Sticky record of every pulse, so short pulses are never missed.
    always @(posedge CORE_CLK_I)
        seen <= clr ? 14'h0000 : seen | {EV_CAPTURE_O, EV_START_O,
            EV_COUNT_O, EV_RETRIGGER_O, EV_OUT_MATCH_O, EV_OUT_WRAP_O,
            PERIOD_COPY_O, CHAN_COPY_O, CMD_COUNT_READ_SYNC_CMD_O, CMD_UPDATE_O,
            CMD_STOP_O, CMD_RETRIGGER_O};

    task tk(input int n);
        repeat (n) @(posedge CORE_CLK_I);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CORE_CLK_I);
        PENABLE_I <= 1'b1;
        do
            @(posedge CORE_CLK_I);
        while (PREADY_O !== 1'b1);
        rdat = PRDATA_O;
        rerr = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task cs();
        clr <= 1'b1;
        tk(1);
        clr <= 1'b0;
    endtask

    task pulse(input logic [3:0] f);
        fire <= f;
        tk(1);
        fire <= 4'h0;
        tk(6);
    endtask

    task test_done();
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        {PSEL_I, PENABLE_I, PWRITE_I, tick_en, clr} = 5'h00;
        {PADDR_I, PWDATA_I, fire} = 44'h0;
        PSTRB_I = 4'hF;
        ev_lvl = 1'b1;
        n_errors = 0;
        cmp_count = 0;
        RST_I = 1'b1;
        tk(2);
        RST_I <= 1'b0;
        rchk(8'h14, 32'h0);
        rchk(8'h18, 32'h0);
        rchk(8'h2C, 32'h1);
        xfer(1'b0, 8'h08, 32'h0);
        chk(32'(rerr), 32'h1);
        for (i = 1; i <= 4; i++)
        begin
            wr(8'h00, 32'h0001_0000 | 32'(i % 4) << 2);
            tk(2);
            chk(32'(WIDTH_SEL_O), 32'(wsel[i - 1]));
            chk(32'(CAPTURE_EN_O), 32'h1);
        end
        wr(8'h18, 32'h3131);
        rchk(8'h18, 32'h3131);
        chk(32'(EV_ACTION_O), 32'h1);
        wr(8'h00, 32'h0001_0002);
        rchk(8'h40, 32'h2);
        rchk(8'h00, 32'h0001_0002);
        repeat (8) if (rdat[1]) xfer(1'b0, 8'h40, 32'h0);
        chk(32'(ENABLED_O), 32'h1);
        wr(8'h18, 32'h0);
        rchk(8'h18, 32'h3131);
        wr(8'h00, 32'h6);
        rchk(8'h00, 32'h0001_0002);
        wr(8'h14, 32'h20);
        rchk(8'h10, 32'h20);
        wr(8'h10, 32'h80);
        rchk(8'h14, 32'h0);
        tick_en <= 1'b1;
        tk(12);
        chk(32'(RUN_O), 32'h0);
        cs();
        for (i = 1; i <= 4; i++)
        begin
            wr(8'h14, 32'(i) << 5);
            tk(10);
            chk(32'(RUN_O), 32'(i == 1));
        end
        rchk(8'h14, 32'h0);
        chk(32'(seen), 32'h7F);
        wr(8'h14, 32'h27);
        tk(10);
        rchk(8'h10, 32'h7);
        chk(32'({ONE_SHOT_O, DIR_DOWN_O, RUN_O}), 32'h7);
        cs();
        pulse(4'hF);
        chk(32'(seen), 32'h390);
        chk(32'(RUN_O), 32'h0);
        wr(8'h10, 32'h7);
        wr(8'h14, 32'h20);
        tk(10);
        chk(32'({ONE_SHOT_O, DIR_DOWN_O, RUN_O}), 32'h1);
        cs();
        pulse(4'h9);
        chk(32'({seen, RUN_O}), 32'h1E1);
        wr(8'h14, 32'h40);
        tk(10);
        cs();
        ev_lvl <= 1'b0;
        tk(10);
        chk(32'({seen[10], RUN_O}), 32'h3);
        wr(8'h00, 32'h7);
        tk(6);
        chk(32'(ENABLED_O), 32'h0);
        rchk(8'h00, 32'h0);
        rchk(8'h18, 32'h0);
        rchk(8'h2C, 32'h1);
        for (i = 2; i <= 4; i++)
        begin
            wr(8'h00, 32'h0);
            ev_lvl <= 1'b0;
            tk(4);
            wr(8'h18, 32'h20 | i);
            wr(8'h00, 32'h2);
            tk(6);
            cs();
            ev_lvl <= 1'b1;
            tk(8);
            chk(32'(seen) >> 11, 32'h1 << (i - 2));
        end
        test_done();
    end

    // The tests take well under a thousand cycles; this cuts off a hang.
    initial
    begin
        #200000;
        n_errors++;
        test_done();
    end
endmodule
